// [dv/tb.sv]
// Purpose: Self-checking bench for the watchdog downcounter behind its Wishbone slave.
// Assumes: Prescaler shortened to 20 cycles and reset phases to 16 and 8 cycles.
// Notes:   Prescaler phase is unknown at a write, so timeouts are checked as windows.
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wdgdc_pkg::*;
    localparam int P  = 20;                  // Shortened prescaler length.
    localparam int PL = 16;                  // Shortened long reset phase.
    localparam int PS = 8;                   // Shortened short reset phase.
    logic          clk         = 1'b0;       // Bench clock.
    logic          rst_n       = 1'b0;       // Synchronous active-low reset.
    wdgdc_wb_req_t req         = '0;         // Wishbone request bundle.
    wdgdc_wb_rsp_t rsp;                      // Wishbone answer bundle.
    logic          hw_opt      = 1'b0;       // Always-armed strap.
    logic          halt_opt    = 1'b0;       // Halt-gives-reset strap.
    logic          long_opt    = 1'b0;       // Long reset phase strap.
    logic          halt_exec   = 1'b0;       // Halt instruction in progress.
    logic          chip_reset, reset_pin_o, reset_pin_oe, halt_block;
    int            miscompares = 0;          // Mismatches seen.
    int            comparisons = 0;          // Comparisons made.
    logic [31:0]   seed        = 32'h4552;   // Random stream state.
    logic [31:0]   rd;                       // Last read data.
    int            n;                        // Scratch step count.

    always #5 clk = ~clk;

    wdgdc_top #(.PRESCALE(P), .PHASE_LONG(PL), .PHASE_SHORT(PS)) u_wdgdc_top (
        .clk(clk), .rst_n(rst_n), .wb_req(req), .wb_rsp(rsp),
        .hw_watchdog_opt(hw_opt), .halt_reset_option(halt_opt),
        .long_phase_opt(long_opt), .halt_exec(halt_exec), .chip_reset(chip_reset),
        .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe), .halt_block(halt_block));

    // Maximal-length style shift register for repeatable stimulus.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // Reset with the straps given for 20 cycles; the strap synchronisers load them only after rst_n rises.
    task automatic do_reset(input logic hw, input logic ho, input logic lp);
        rst_n    <= 1'b0;
        hw_opt   <= hw;
        halt_opt <= ho;
        long_opt <= lp;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : do_reset

    // One classic cycle; request held until ack is sampled, then one idle cycle.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int k;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rsp.ack !== 1'b1 && k < 50);
        q = rsp.dat;
        if (k >= 50) begin
            miscompares++;
            end_sim();
        end
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    // Waits for a trip in [lo, hi) cycles, then measures pin-low and phase lengths.
    task automatic trip(input int lo, input int hi, input int ph);
        int k, o, c;
        k = 0;
        while (chip_reset !== 1'b1 && k < hi) begin
            @(posedge clk);
            k++;
        end
        if (k >= hi) begin
            miscompares++;
            end_sim();
        end
        `CHK(k >= lo, 1'b1)
        `CHK(reset_pin_o, 1'b0)
        o = 0;
        c = 0;
        while (chip_reset === 1'b1 && c < 5000) begin
            o += (reset_pin_oe === 1'b1);
            c++;
            @(posedge clk);
        end
        `CHK(o >= 3599 && o <= WDGDC_PIN_LOW_CYC, 1'b1)
        `CHK(c - o >= ph && c - o <= ph + 1, 1'b1)
        do_reset(1'b0, 1'b0, 1'b0);
    endtask : trip

    initial begin
        do_reset(1'b0, 1'b1, 1'b1);
        // Register reset value, options readback and an unmapped place.
        wb(1'b0, WDGDC_CONTROL_OFS, '0, rd);
        `CHK(rd, {24'h0, WDGDC_CONTROL_RST})
        wb(1'b0, WDGDC_OPTIONS_OFS, '0, rd);
        `CHK(rd, 32'h0000_0006)
        wb(1'b0, 8'h10, '0, rd);
        `CHK(rd, 32'h0)
        // Disarmed counter keeps running past 40h without a reset.
        wb(1'b1, WDGDC_CONTROL_OFS, 32'h41, rd);
        repeat (4 * P - 4) @(posedge clk);
        wb(1'b0, WDGDC_CONTROL_OFS, '0, rd);
        `CHK(rd >= 32'h3C && rd <= 32'h3E, 1'b1)
        `CHK(chip_reset, 1'b0)
        $display("test free_run done");
        // Armed timeouts with random delays, both reset phase lengths.
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            n = 1 + int'(seed[2:0]);
            do_reset(1'b0, 1'b0, i[0]);
            wb(1'b1, WDGDC_CONTROL_OFS, 32'hC0 | n, rd);
            trip(n * P - 4, (n + 1) * P + 6, i ? PL : PS);
        end
        $display("test timeout done");
        // Arm bit survives a disarming write; the count still loads.
        wb(1'b1, WDGDC_CONTROL_OFS, 32'hFF, rd);
        wb(1'b1, WDGDC_CONTROL_OFS, 32'h7F, rd);
        wb(1'b0, WDGDC_CONTROL_OFS, '0, rd);
        `CHK(rd[7], 1'b1)
        `CHK(rd[6:0] >= 7'h7D, 1'b1)
        do_reset(1'b0, 1'b0, 1'b0);
        // Software reset by arm set and top bit clear.
        wb(1'b1, WDGDC_CONTROL_OFS, 32'h80, rd);
        trip(0, 4, PS);
        // Halt with the option allowed and armed turns into a reset.
        do_reset(1'b0, 1'b1, 1'b0);
        wb(1'b1, WDGDC_CONTROL_OFS, 32'hFF, rd);
        halt_exec <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK(halt_block, 1'b1)
        halt_exec <= 1'b0;
        trip(0, 4, PS);
        // Hardware option arms the watchdog although the arm bit is clear.
        do_reset(1'b1, 1'b0, 1'b0);
        wb(1'b1, WDGDC_CONTROL_OFS, 32'h41, rd);
        trip(P - 4, 2 * P + 6, PS);
        $display("test options done");
        end_sim();
    end
endmodule : tb

// [hdl/wdgdc_pkg.sv]
// Purpose: Shared constants and types for the watchdog downcounter block.
// Assumes: Wishbone classic slave with 32-bit data, byte addresses.
// Notes:   Every offset, control field position, reset value and timing count lives here.
package wdgdc_pkg;
    // Register map: control word at byte address zero, options word at byte address four.
    localparam logic [7:0]  WDGDC_CONTROL_OFS   = 8'h00;
    localparam logic [7:0]  WDGDC_OPTIONS_OFS   = 8'h04;
    // Control register fields.
    localparam int          WDGDC_ARM_POS       = 7;
    localparam int          WDGDC_TOP_POS       = 6;
    localparam logic [7:0]  WDGDC_CONTROL_RST   = 8'h7F;
    // Counter value that trips the reset when it is left behind.
    localparam logic [6:0]  WDGDC_TRIP_FROM     = 7'h40;
    // Prescaler length in machine cycles.
    localparam int          WDGDC_PRESCALE      = 16000;
    // Reset pin low time in nanoseconds and its cycle count at 100 MHz.
    localparam int          WDGDC_CLK_MHZ       = 100;
    localparam int          WDGDC_PIN_LOW_NS    = 36000;
    localparam int          WDGDC_PIN_LOW_CYC   = (WDGDC_PIN_LOW_NS * WDGDC_CLK_MHZ) / 1000;
    // Added reset phase lengths in CPU cycles.
    localparam int          WDGDC_PHASE_SHORT   = 256;
    localparam int          WDGDC_PHASE_LONG    = 4096;

    // Reset sequencer states.
    typedef enum logic [1:0] {
        WDGDC_IDLE,
        WDGDC_PIN_LOW,
        WDGDC_PHASE
    } wdgdc_state_t;

    // Wishbone request carried as one bundle.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wdgdc_wb_req_t;

    // Wishbone answer carried as one bundle.
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wdgdc_wb_rsp_t;
endpackage : wdgdc_pkg

// [hdl/wdgdc_top.sv]
// Purpose: Watchdog with a free-running 7-bit downcounter behind a Wishbone slave.
// Assumes: One 100 MHz clock, synchronous active-low reset, option straps static.
// Notes:   The chip reset request and the reset pin drive come from flip-flops.
// What this block does
// - Decrement counter once per 16000 machine cycles.
// - Armed: 40h to 3Fh starts pin-low reset.
// - Counter always decrements, armed or not.
// - Disarmed after reset; only reset disarms.
// - Armed write with top bit clear resets.
// - Armed halt with option set gives reset.
// - Hardware option keeps watchdog always armed.
// - Control resets to 7Fh; arm bit seven.
// - Timeout has 64 steps from low bits.
// - Writes never clear the prescaler.
// - Add 256 or 4096 cycle reset phase.
module wdgdc_top
    import wdgdc_pkg::*;
#(
    parameter int PRESCALE    = WDGDC_PRESCALE,
    parameter int PHASE_LONG  = WDGDC_PHASE_LONG,
    parameter int PHASE_SHORT = WDGDC_PHASE_SHORT
) (
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Wishbone slave.
    input  wire wdgdc_wb_req_t wb_req,
    output wdgdc_wb_rsp_t      wb_rsp,
    // Option straps and core signals, from pins or another domain.
    input  wire logic          hw_watchdog_opt,
    input  wire logic          halt_reset_option,
    input  wire logic          long_phase_opt,
    input  wire logic          halt_exec,
    // Reset outputs and the halt hold-off.
    output logic               chip_reset,
    output logic               reset_pin_o,
    output logic               reset_pin_oe,
    output logic               halt_block
);
    localparam int PRE_W   = $clog2(PRESCALE);
    localparam int PHASE_W = $clog2(PHASE_LONG + 1);
    localparam int PIN_W   = $clog2(WDGDC_PIN_LOW_CYC + 1);

    // Two-stage synchronisers for the four external levels.
    logic [3:0]       sync1_r;        // First stage, read only by the second.
    logic [3:0]       sync2_r;        // Second stage, safe to use.
    logic             hw_opt;         // Hardware watchdog option.
    logic             halt_opt;       // Halt-causes-reset option.
    logic             long_opt;       // Selects the long reset phase.
    logic             halt_req;       // Halt instruction executing.

    // Watchdog state.
    logic [PRE_W-1:0] pre_r;          // Prescaler, never cleared by writes.
    logic             tick;           // One cycle per prescaler wrap.
    logic [6:0]       count_r;        // The seven counter bits.
    logic             arm_r;          // Software arm bit.
    logic             armed;          // Effective arm, including hardware option.
    logic             ctl_write;      // Accepted write to the control low byte.
    logic             trip_count;     // Counter left 40h while armed.
    logic             trip_write;     // Software-triggered reset.
    logic             trip_halt;      // Halt turned into a reset.
    logic             trip;           // Any cause.

    // Reset sequencer.
    wdgdc_state_t       state_r;
    logic [PIN_W-1:0]   pin_cnt_r;    // Pin-low cycle count.
    logic [PHASE_W-1:0] phase_cnt_r;  // Added reset phase count.

    // Bus signals.
    logic             hit;            // Request addresses a mapped register.
    logic             ack_r;          // Acknowledge, one cycle per request.
    logic [31:0]      rdat_r;         // Registered read data.

    assign hw_opt   = sync2_r[0];
    assign halt_opt = sync2_r[1];
    assign long_opt = sync2_r[2];
    assign halt_req = sync2_r[3];

    // Straps and the halt strobe come from outside this clock, so they are
    // resynchronised; the halt strobe must stay high at least three cycles.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end else begin
            sync1_r <= {halt_exec, long_phase_opt, halt_reset_option, hw_watchdog_opt};
            sync2_r <= sync1_r;
        end
    end

    // Prescaler runs free; a register write does not touch it, so the first
    // step after a reload can be anywhere between zero and one full step.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_r <= '0;
        end else if (tick) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + PRE_W'(1);
        end
    end
    assign tick = (pre_r == PRE_W'(PRESCALE - 1));

    // Effective arm: the hardware option overrides the software bit.
    assign armed = arm_r | hw_opt;

    // Bus decode: an access is taken in the cycle it appears without ack.
    assign hit       = (wb_req.adr == WDGDC_CONTROL_OFS) || (wb_req.adr == WDGDC_OPTIONS_OFS);
    assign ctl_write = wb_req.cyc && wb_req.stb && !ack_r && wb_req.we
                       && wb_req.sel[0] && (wb_req.adr == WDGDC_CONTROL_OFS);

    // Counter: loaded whole by a write, otherwise it steps down every tick
    // whether or not the watchdog is armed.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_r <= WDGDC_CONTROL_RST[6:0];
        end else if (ctl_write) begin
            count_r <= wb_req.dat[6:0];
        end else if (tick) begin
            count_r <= count_r - 7'h01;
        end
    end

    // Arm bit: writes can only set it; reset is the only way back.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arm_r <= WDGDC_CONTROL_RST[WDGDC_ARM_POS];
        end else if (ctl_write && wb_req.dat[WDGDC_ARM_POS]) begin
            arm_r <= 1'b1;
        end
    end

    // Reset causes.  A write is evaluated with the arm state it brings along,
    // so one write with arm set and top bit clear resets at once.
    assign trip_count = armed && tick && !ctl_write
                        && (count_r == WDGDC_TRIP_FROM);
    assign trip_write = ctl_write && (armed || wb_req.dat[WDGDC_ARM_POS])
                        && !wb_req.dat[WDGDC_TOP_POS];
    assign trip_halt  = armed && halt_opt && halt_req;
    assign trip       = trip_count | trip_write | trip_halt;

    // Halt is held off whenever it would be converted into a reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            halt_block <= 1'b0;
        end else begin
            halt_block <= armed && halt_opt;
        end
    end

    // Reset sequencer: drive the pin low, then hold the chip reset for the
    // added phase.  The chip reset ends by itself when the phase count runs out.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r     <= WDGDC_IDLE;
            pin_cnt_r   <= '0;
            phase_cnt_r <= '0;
        end else begin
            unique case (state_r)
                WDGDC_IDLE: begin
                    if (trip) begin
                        state_r   <= WDGDC_PIN_LOW;
                        pin_cnt_r <= PIN_W'(WDGDC_PIN_LOW_CYC - 1);
                    end
                end
                WDGDC_PIN_LOW: begin
                    if (pin_cnt_r == '0) begin
                        state_r     <= WDGDC_PHASE;
                        phase_cnt_r <= long_opt ? PHASE_W'(PHASE_LONG - 1)
                                                : PHASE_W'(PHASE_SHORT - 1);
                    end else begin
                        pin_cnt_r <= pin_cnt_r - PIN_W'(1);
                    end
                end
                WDGDC_PHASE: begin
                    if (phase_cnt_r == '0) begin
                        state_r <= WDGDC_IDLE;
                    end else begin
                        phase_cnt_r <= phase_cnt_r - PHASE_W'(1);
                    end
                end
                default: begin
                    state_r <= WDGDC_IDLE;
                end
            endcase
        end
    end

    // Outputs from flip-flops so they are glitch free toward the pad.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chip_reset   <= 1'b0;
            reset_pin_oe <= 1'b0;
        end else begin
            chip_reset   <= (state_r != WDGDC_IDLE) || trip;
            reset_pin_oe <= (state_r == WDGDC_IDLE) ? trip
                            : (state_r == WDGDC_PIN_LOW) && (pin_cnt_r != '0);
        end
    end
    // Open drain: the pin is only ever pulled low.
    assign reset_pin_o = 1'b0;

    // Bus answer: one wait-free ack a cycle after the request is seen.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= wb_req.cyc && wb_req.stb && !ack_r;
            if (wb_req.cyc && wb_req.stb && !ack_r && !wb_req.we) begin
                if (wb_req.adr == WDGDC_CONTROL_OFS) begin
                    rdat_r <= {24'h00_0000, arm_r, count_r};
                end else if (hit) begin
                    rdat_r <= {29'h0000_0000, long_opt, halt_opt, hw_opt};
                end else begin
                    rdat_r <= 32'h0000_0000;
                end
            end
        end
    end
    assign wb_rsp.ack = ack_r;
    assign wb_rsp.dat = rdat_r;

    // Checks and coverage.
    // Ticks are spaced at least nine cycles apart.
    tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> !tick [*8]) else $error("Prescaler ticks too close.");
    count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && !ctl_write) |=> count_r == $past(count_r) - 7'h01)
        else $error("Counter did not step down.");
    trip_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == WDGDC_IDLE && trip_count) |=> reset_pin_oe && chip_reset)
        else $error("Expiry did not pull the reset pin.");
    arm_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        arm_r |=> arm_r) else $error("Arm bit was cleared.");
    soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == WDGDC_IDLE && ctl_write && wb_req.dat[7:6] == 2'b10)
        |=> chip_reset) else $error("Software reset missing.");
    halt_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == WDGDC_IDLE && arm_r && halt_opt && halt_req) |=> chip_reset)
        else $error("Halt did not reset.");
    hw_arm_a: assert property (@(posedge clk) disable iff (!rst_n)
        (hw_opt && state_r == WDGDC_IDLE && tick && !ctl_write
         && count_r == 7'h40) |=> chip_reset) else $error("Hardware arm ignored.");
    load_word_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctl_write |=> count_r == $past(wb_req.dat[6:0]))
        else $error("Write did not load the counter.");
    phase_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == WDGDC_PHASE) |-> chip_reset) else $error("Phase lost reset.");
    cover_expiry: cover property (@(posedge clk) trip_count);
    cover_soft:   cover property (@(posedge clk) trip_write);
    cover_halt:   cover property (@(posedge clk) trip_halt);
    cover_read:   cover property (@(posedge clk) ack_r && !wb_req.we);
    cover_hw_arm: cover property (@(posedge clk) hw_opt && trip_count);

    // Helper logic for the checks below.  A run counter of the pin drive lets
    // the pin-low length be asserted without a long repetition, which the
    // property engines would otherwise have to unroll cycle by cycle.
    // It is pure checking logic and drives no output of the block.
    logic [PIN_W:0]   oe_run_r;       // Cycles the reset pin has been driven low.

    // Counts while the pin is pulled low and clears as soon as it is let go.
    // One bit wider than the pin counter so a runaway drive cannot wrap back.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oe_run_r <= '0;
        end else if (reset_pin_oe) begin
            oe_run_r <= oe_run_r + (PIN_W+1)'(1);
        end else begin
            oe_run_r <= '0;
        end
    end

    // The pin is never pulled for longer than the nominal low time.
    pin_long_a: assert property (@(posedge clk) disable iff (!rst_n)
        oe_run_r <= (PIN_W+1)'(WDGDC_PIN_LOW_CYC))
        else $error("Reset pin held too long.");

    // When the pin is let go it has been pulled for exactly the low time.
    pin_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(reset_pin_oe) |-> oe_run_r == (PIN_W+1)'(WDGDC_PIN_LOW_CYC))
        else $error("Reset pin low time wrong.");

    // Reset leaves the arm bit clear and the counter at its reset code.
    // This one runs during reset as well, so it has no disable clause.
    reset_value_a: assert property (@(posedge clk)
        !rst_n |=> !arm_r && count_r == WDGDC_CONTROL_RST[6:0])
        else $error("Control register reset value wrong.");

    // A write with the arm bit set always leaves the watchdog armed.
    arm_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctl_write && wb_req.dat[WDGDC_ARM_POS]) |=> arm_r)
        else $error("Arming write was lost.");

    // A write away from a tick still lets the prescaler step on, which is
    // why a reload can shorten the first step by up to one full step.
    pre_free_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctl_write && !tick) |=> pre_r == $past(pre_r) + PRE_W'(1))
        else $error("Write disturbed the prescaler.");

    // The short phase length is loaded when the pin is let go.
    phase_short_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == WDGDC_PIN_LOW && pin_cnt_r == '0 && !long_opt)
        |=> phase_cnt_r == PHASE_W'(PHASE_SHORT - 1))
        else $error("Short reset phase not loaded.");

    // The long phase length is loaded when the strap asks for it.
    phase_long_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == WDGDC_PIN_LOW && pin_cnt_r == '0 && long_opt)
        |=> phase_cnt_r == PHASE_W'(PHASE_LONG - 1))
        else $error("Long reset phase not loaded.");

    // A new cause during the added reset phase must not restart or end it.
    no_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == WDGDC_PHASE && phase_cnt_r != '0) |=> state_r == WDGDC_PHASE)
        else $error("Reset sequence restarted.");

    // Halt is held off for as long as it would be turned into a reset.
    halt_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (armed && halt_opt) |=> halt_block)
        else $error("Halt was not held off.");

    // Every request is answered by a single-cycle acknowledge.
    ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        ack_r |=> !ack_r)
        else $error("Acknowledge stood too long.");
endmodule : wdgdc_top
